/* apd_host.sv */
// Purpose: host controller driving an async page-mode DRAM module
// Assumes: strobes and address are driven from flip-flops
// Notes:   presence store bus is left to a separate I2C master
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Write strobe level alone picks read (high) or write (low).
// - Late write: raise output enable before driving write data (this block issues early writes only).
// - Access opens with row address on row fall, then column.
// - Further columns: keep row low, new column per column pulse.
// - Raising row strobe ends the page and closes the row.
// - Every row must be activated once per refresh period.
// - 4096 column-before-row refreshes spread over each 64 ms.
// - Presence store reached over I2C, three select pins, eight addresses (left to a separate I2C master).
module apd_host
  import apd_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              clk_en_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ROW_W-1:0]  req_row_i,
  input  wire logic [COL_W-1:0]  req_col_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              req_last_i,
  input  wire logic              edo_mode_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic      [DATA_W-1:0] rsp_rdata_o,
  output logic                   busy_o,
  output logic      [ADDR_W-1:0] mem_addr_o,
  output logic                   row_strobe_n_o,
  output logic                   col_strobe_n_o,
  output logic                   write_n_o,
  output logic                   out_en_n_o,
  input  wire logic [DATA_W-1:0] mem_dq_i,
  output logic      [DATA_W-1:0] mem_dq_o,
  output logic                   mem_dq_oe_o
);
  // ==========================================================
  // Reset release and pin synchroniser
  logic              rst_s1_q;
  logic              rst_n;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end
    else if (clk_en_i)
    begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end
  // ==========================================================
  // State and counters
  apd_state_t       st_q;
  apd_state_t       st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] ref_q;
  logic             ref_pend_q;
  logic             wr_q;
  logic             last_q;
  logic [COL_W-1:0] col_q;
  logic [DATA_W-1:0] wd_q;
  logic             samp_q;
  logic             samp2_q;
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc
  wire logic cnt_done = (cnt_q == CNT_ZERO);
  wire logic ref_tick = (ref_q == CNT_ZERO);
  wire logic take     = req_valid_i && !ref_pend_q;
  // Refresh waits for idle so no open page is cut short
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_done ? cnt_q : CNT_W'(cnt_q - 1'b1);
    case (st_q)
      ST_IDLE:
        if (cnt_done && ref_pend_q)
        begin
          st_d  = ST_CBR_C;
          cnt_d = cyc(STROBE_CYC);
        end
        else if (cnt_done && take)
        begin
          st_d  = ST_ROW;
          cnt_d = cyc(STROBE_CYC);
        end
      ST_ROW:
        if (cnt_done)
        begin
          st_d  = ST_COL;
          cnt_d = cyc(STROBE_CYC);
        end
      ST_COL:
        if (cnt_done)
        begin
          st_d  = ST_CPRE;
          cnt_d = cyc(COL_PRE_CYC);
        end
      ST_CPRE:
        if (cnt_done)
          st_d = last_q ? ST_RPRE : ST_OPEN;
      ST_OPEN:
        if (req_valid_i)
        begin
          st_d  = ST_COL;
          cnt_d = cyc(STROBE_CYC);
        end
      ST_RPRE:
      begin
        st_d  = ST_IDLE;
        cnt_d = cyc(ROW_PRE_CYC);
      end
      ST_CBR_C:
        if (cnt_done)
        begin
          st_d  = ST_CBR_R;
          cnt_d = cyc(STROBE_CYC);
        end
      ST_CBR_R:
        if (cnt_done)
          st_d = ST_CBR_E;
      ST_CBR_E:
      begin
        st_d  = ST_IDLE;
        cnt_d = cyc(ROW_PRE_CYC);
      end
      default:
        st_d = ST_IDLE;
    endcase
  end
  wire logic col_start = (st_d == ST_COL) && (st_q != ST_COL);
  wire logic col_end   = (st_q == ST_COL) && cnt_done;
  // EXTENDED_OUTPUT_PAGE_ACCESS keeps data past column rise, so sample one cycle later
  wire logic samp      = col_end && !wr_q;
  // Pin data reaches dq_s2_q two edges late, so the take is delayed too
  wire logic rd_take   = edo_mode_i ? samp2_q : samp_q;
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_q  <= 1'b0;
      samp2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      samp_q  <= samp;
      samp2_q <= samp_q;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= ST_IDLE;
      cnt_q      <= CNT_ZERO;
      ref_q      <= CNT_ZERO;
      ref_pend_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      ref_q <= ref_tick ? cyc(REF_INT_CYC) : CNT_W'(ref_q - 1'b1);
      // A tick in the serve cycle is kept: set wins over clear
      if (ref_tick)
        ref_pend_q <= 1'b1;
      else if (st_q == ST_CBR_E)
        ref_pend_q <= 1'b0;
    end
  end
  // ==========================================================
  // Request capture
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q   <= 1'b0;
      last_q <= 1'b0;
      col_q  <= '0;
      wd_q   <= '0;
    end
    else if (clk_en_i && col_start)
    begin
      wr_q   <= req_write_i;
      last_q <= req_last_i;
      col_q  <= req_col_i;
      wd_q   <= req_wdata_i;
    end
  end
  // ==========================================================
  // Pin drive
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr_o     <= '0;
      row_strobe_n_o <= 1'b1;
      col_strobe_n_o <= 1'b1;
      write_n_o      <= 1'b1;
      out_en_n_o     <= 1'b1;
      mem_dq_o       <= '0;
      mem_dq_oe_o    <= 1'b0;
      req_ready_o    <= 1'b0;
      rsp_valid_o    <= 1'b0;
      busy_o         <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // Row on pins first, then column, each held by state
      if (st_d == ST_ROW)
        mem_addr_o <= req_row_i;
      else if (col_start)
        mem_addr_o <= ADDR_W'(req_col_i);
      // Row low for the whole page, high ends it
      row_strobe_n_o <= !(st_d inside {ST_COL, ST_CPRE, ST_OPEN, ST_CBR_R}
                          || (st_d == ST_ROW && cnt_q != CNT_ZERO)
                          || st_q == ST_ROW);
      // Column falls before row for refresh, no address needed
      // Column falls one cycle after its address appears, giving setup
      col_strobe_n_o <= !((st_d == ST_COL && !col_start)
                          || st_d == ST_CBR_C
                          || st_d == ST_CBR_R);
      // Early write only: write low before column falls
      write_n_o      <= !(col_start ? req_write_i
                          : (st_d == ST_COL && wr_q));
      // Output enable stays high on writes so data never collides
      out_en_n_o     <= !(st_d == ST_COL && !(col_start ? req_write_i : wr_q));
      mem_dq_o       <= col_start ? req_wdata_i : wd_q;
      mem_dq_oe_o    <= (st_d == ST_COL) && (col_start ? req_write_i : wr_q);
      req_ready_o    <= col_start;
      // Fast-page data floats at column rise, sample before it
      rsp_valid_o    <= rd_take;
      busy_o         <= (st_d != ST_IDLE);
    end
  end
  apd_rdbuf apd_rdbuf_i (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .en_i    (clk_en_i),
    .wr_i    (rd_take),
    .wdata_i (dq_s2_q),
    .rdata_o (rsp_rdata_o)
  );
endmodule : apd_host
`default_nettype wire

/* apd_pkg.sv */
// Purpose: constants for the page-mode DRAM host controller
// Assumes: 40 MHz clock, 12 shared address pins, 32-bit data
// Notes:   timing counts derive from times in ns
package apd_pkg;
  // ==========================================================
  // Widths and clock period
  localparam int unsigned ROW_W  = 12;
  localparam int unsigned COL_W  = 10;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CLK_NS = 25;
  // ==========================================================
  // Timing, in ns (refresh period in ms) as printed or chosen, then in cycles
  localparam int unsigned ROW_PRE_NS   = 40;
  localparam int unsigned COL_PRE_NS   = 10;
  localparam int unsigned STROBE_NS    = 60;
  localparam int unsigned REF_PERIOD_MS = 64;
  localparam int unsigned REF_ROWS     = 4096;
  localparam int unsigned ROW_PRE_CYC  = (ROW_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned COL_PRE_CYC  = (COL_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Longest spacing between refreshes rounds down
  localparam int unsigned REF_INT_CYC  =
    (REF_PERIOD_MS * 1000000 / REF_ROWS) / CLK_NS;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ROW    = 4'h1,
    ST_COL    = 4'h2,
    ST_CPRE   = 4'h3,
    ST_OPEN   = 4'h4,
    ST_RPRE   = 4'h5,
    ST_CBR_C  = 4'h6,
    ST_CBR_R  = 4'h7,
    ST_CBR_E  = 4'h8
  } apd_state_t;
endpackage : apd_pkg

/* apd_rdbuf.sv */
// Purpose: holds the read word caught from the module data pins
// Assumes: single clock, write and read on same edge domain
// Notes:   read data leaves a register
`timescale 1ns/10ps
`default_nettype none
module apd_rdbuf
  import apd_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              en_i,
  input  wire logic              wr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  // ==========================================================
  // Storage
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (en_i && wr_i)
      rdata_o <= wdata_i;
  end
endmodule : apd_rdbuf
`default_nettype wire

/* apd_host_monitor.sv */
// Purpose: pin checks for apd_host
// Assumes: early writes only
// Notes:   refresh gap held in a counter
`timescale 1ns/10ps
`default_nettype none
module apd_host_monitor
  import apd_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rstn_i,
  input wire logic              rsp_valid_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              row_strobe_n_o,
  input wire logic              col_strobe_n_o,
  input wire logic              write_n_o,
  input wire logic              out_en_n_o,
  input wire logic              mem_dq_oe_o
);
  // ====================
  // Checks
  localparam int GAP_MAX = REF_INT_CYC + 75;
  logic [CNT_W-1:0] gap_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Slack covers a refresh held back by a short page
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      gap_q <= CNT_ZERO;
    else if (row_strobe_n_o && !col_strobe_n_o)
      gap_q <= CNT_ZERO;
    else
      gap_q <= gap_q + 16'h0001;
  a_col_addr_hold: assert property (
    $fell(col_strobe_n_o) && !row_strobe_n_o
      |-> $stable(mem_addr_o) ##1 $stable(mem_addr_o))
    else $error("column address moved");
  a_write_oe_off: assert property (
    !write_n_o && !col_strobe_n_o |-> out_en_n_o)
    else $error("oe low in write");
  a_drive_oe_off: assert property (
    mem_dq_oe_o |-> out_en_n_o)
    else $error("data driven with oe low");
  a_type_steady: assert property (
    !col_strobe_n_o && !$past(col_strobe_n_o) |-> $stable(write_n_o))
    else $error("write level moved");
  a_cbr_precharge: assert property (
    $fell(col_strobe_n_o) && row_strobe_n_o
      |-> $past(row_strobe_n_o) && $past(row_strobe_n_o, 2))
    else $error("refresh without precharge");
  a_cbr_row_fall: assert property (
    $fell(col_strobe_n_o) && row_strobe_n_o
      |-> ##[1:16] $fell(row_strobe_n_o))
    else $error("refresh row fall missing");
  a_col_pulse_end: assert property (
    $fell(col_strobe_n_o) |-> ##[1:16] $rose(col_strobe_n_o))
    else $error("column pulse too long");
  a_refresh_gap: assert property (
    gap_q <= GAP_MAX)
    else $error("refresh gap too long");
  c_read: cover property ($rose(rsp_valid_o));
  c_write: cover property (!write_n_o && !col_strobe_n_o);
  c_refresh: cover property (!col_strobe_n_o && row_strobe_n_o);
endmodule : apd_host_monitor
`default_nettype wire

/* apd_dram_model.sv */
// Purpose: behavioural page-mode DRAM module
// Assumes: strobes move only at clock edges
// Notes:   released data pins show the inverse of the last word
`timescale 1ns/10ps
`default_nettype none
module apd_dram_model
  import apd_pkg::*;
(
  input  wire logic              edo_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              row_n_i,
  input  wire logic              col_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic [DATA_W-1:0] d_i,
  output logic      [DATA_W-1:0] q_o,
  output int                     ref_cnt_o
);
  // ====================
  // Cells and strobes
  logic [DATA_W-1:0]      mem [logic [ROW_W+COL_W-1:0]];
  logic [ROW_W-1:0]       row_q = 12'h000;
  logic [ROW_W-1:0]       ref_row_q = 12'h000;
  logic [ROW_W+COL_W-1:0] key;
  logic [DATA_W-1:0]      last_q = 32'h0000_0000;
  logic                   hold_q = 1'b0;
  wire                    drive;
  initial ref_cnt_o = 0;
  // Sample a step late: pins and strobes move in one time step
  always @(negedge row_n_i)
    #1 row_q = col_n_i ? addr_i : ref_row_q;
  always @(negedge col_n_i)
  begin
    #1;
    if (row_n_i)
    begin
      ref_cnt_o++;
      ref_row_q++;
    end
    else
    begin
      key = {row_q, addr_i[COL_W-1:0]};
      // Late writes never store, so read data stays
      if (!we_n_i) mem[key] = d_i;
      last_q = mem.exists(key) ? mem[key] : 32'h0000_0000;
      hold_q = we_n_i;
    end
  end
  always @(posedge row_n_i or posedge oe_n_i)
    if (row_n_i || col_n_i) hold_q = 1'b0;
  assign drive = !row_n_i && !oe_n_i && we_n_i
    && (!col_n_i || (edo_i && hold_q));
  assign q_o = drive ? last_q : ~last_q;
endmodule : apd_dram_model
`default_nettype wire

/* test_apd_host.sv */
// Purpose: self-checking bench for apd_host
// Assumes: 40 MHz clock, DRAM model on the pins
// Notes:   refresh seen through the model's counter
`timescale 1ns/10ps
`default_nettype none
module test_apd_host;
  import apd_pkg::*;
  // ====================
  // Bench
  logic              clock_i, rstn_i, clk_en_i, req_valid_i;
  logic              req_write_i, req_last_i, edo_mode_i;
  logic [ROW_W-1:0]  req_row_i;
  logic [COL_W-1:0]  req_col_i;
  logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, mem_dq_i, mem_dq_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic              req_ready_o, rsp_valid_o, busy_o, mem_dq_oe_o;
  logic              row_strobe_n_o, col_strobe_n_o, write_n_o;
  logic              out_en_n_o;
  int                errors, check_count, ref_cnt;
  apd_host apd_host_i (.clock_i, .rstn_i, .clk_en_i, .req_valid_i,
    .req_write_i, .req_row_i, .req_col_i, .req_wdata_i, .req_last_i,
    .edo_mode_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .busy_o,
    .mem_addr_o, .row_strobe_n_o, .col_strobe_n_o, .write_n_o,
    .out_en_n_o, .mem_dq_i, .mem_dq_o, .mem_dq_oe_o);
  apd_dram_model apd_dram_model_i (.edo_i(edo_mode_i),
    .addr_i(mem_addr_o), .row_n_i(row_strobe_n_o),
    .col_n_i(col_strobe_n_o), .we_n_i(write_n_o), .oe_n_i(out_en_n_o),
    .d_i(mem_dq_o), .q_o(mem_dq_i), .ref_cnt_o(ref_cnt));
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic access(input logic w, input logic [ROW_W-1:0] r,
    input logic [COL_W-1:0] c, input logic [DATA_W-1:0] d, input logic l);
    int n;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_row_i <= r;
    req_col_i <= c;
    req_wdata_i <= d;
    req_last_i <= l;
    for (n = 0; n < 100 && req_ready_o !== 1'b1; n++) @(posedge clock_i);
    req_valid_i <= 1'b0;
    check({31'h0, req_ready_o}, 32'h1);
    if (!w)
    begin
      for (n = 0; n < 40 && rsp_valid_o !== 1'b1; n++) @(posedge clock_i);
      @(posedge clock_i);
      check(rsp_rdata_o, d);
    end
  endtask : access
  task automatic t_page(input logic extended_output_page_access);
    edo_mode_i <= extended_output_page_access;
    access(1'b1, 12'h005, 10'h003, 32'hA5A5_0001, 1'b0);
    access(1'b1, 12'h005, 10'h3FF, 32'h5A5A_00FE, 1'b0);
    access(1'b0, 12'h005, 10'h003, 32'hA5A5_0001, 1'b0);
    access(1'b0, 12'h005, 10'h3FF, 32'h5A5A_00FE, 1'b1);
    access(1'b1, 12'hFFF, 10'h000, 32'hC3C3_3C3C, 1'b1);
    access(1'b0, 12'hFFF, 10'h000, 32'hC3C3_3C3C, 1'b1);
    $display("page test done, edo %0d", extended_output_page_access);
  endtask : t_page
  task automatic t_freeze();
    logic [1:0] s;
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    @(posedge clock_i);
    s = {row_strobe_n_o, col_strobe_n_o};
    repeat (10) @(posedge clock_i);
    check({30'h0, row_strobe_n_o, col_strobe_n_o}, {30'h0, s});
    clk_en_i <= 1'b1;
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_refresh();
    int c0;
    c0 = ref_cnt;
    repeat (1400) @(posedge clock_i);
    c0 = ref_cnt - c0;
    check({31'h0, c0 >= 1400 / REF_INT_CYC
      && c0 <= 1400 / REF_INT_CYC + 1}, 32'h1);
    access(1'b0, 12'h005, 10'h003, 32'hA5A5_0001, 1'b1);
    $display("refresh test done");
  endtask : t_refresh
  initial
  begin
    errors = 0;
    check_count = 0;
    rstn_i = 1'b0;
    clk_en_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_last_i = 1'b0;
    edo_mode_i = 1'b0;
    req_row_i = 12'h000;
    req_col_i = 10'h000;
    req_wdata_i = 32'h0000_0000;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_page(1'b0);
    t_page(1'b1);
    t_freeze();
    t_refresh();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    errors++;
    final_report();
  end
endmodule : test_apd_host
bind apd_host apd_host_monitor apd_host_monitor_i (.clock_i, .rstn_i,
  .rsp_valid_o, .mem_addr_o, .row_strobe_n_o, .col_strobe_n_o,
  .write_n_o, .out_en_n_o, .mem_dq_oe_o);
`default_nettype wire
